/* File: hw/rcam_top.sv */
// receive control alias, global control and receive bit mask register bank
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rcam_top
   import rcam_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   // axi4-lite slave
   input wire logic [RCAM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [RCAM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // control levels to the serial port sections
   output logic rx_frame_sync_gen_run_o,
   output logic rx_state_machine_run_o,
   output logic rx_serializer_active_o,
   output logic rx_hf_divider_run_o,
   output logic rx_hf_divider_bypass_o,
   output logic rx_divider_run_o,
   output logic tx_frame_sync_gen_run_o,
   output logic tx_state_machine_run_o,
   output logic tx_serializer_active_o,
   output logic tx_hf_divider_run_o,
   output logic tx_divider_run_o,
   // received word after reverse and rotate, and its masked result
   input wire logic [DATA_W-1:0] rx_word_i,
   input wire logic rx_word_valid_i,
   output logic [DATA_W-1:0] rx_data_o,
   output logic rx_data_valid_o
);

   // ****************************************
   // byte-lane merge
   // ****************************************
   function automatic logic [31:0] rcam_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb, input logic [31:0] keep);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      rcam_merge = (res & keep) | (old_v & ~keep);
   endfunction

   // ****************************************
   // registers
   // ****************************************
   // single store for global control, the alias writes into it too
   logic [31:0] gctl_r;
   logic [31:0] gctl_nxt;
   logic [31:0] mask_r;
   logic [31:0] mask_nxt;
   logic [31:0] pad_r;
   logic [31:0] pad_nxt;

   // ****************************************
   // write channel
   // ****************************************
   rcam_ch_state_t wr_state_r;
   logic aw_held_r;
   logic w_held_r;
   logic [RCAM_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic wr_hit_global;
   logic wr_hit_alias;
   logic wr_hit_mask;
   logic wr_hit_pad;
   logic wr_mapped;
   logic gctl_we;
   logic alias_we;
   logic mask_we;
   logic pad_we;
   logic [31:0] gctl_keep;
   logic [31:0] alias_keep;

   assign s_axi_awready = (wr_state_r == RCAM_CH_IDLE) && !aw_held_r;
   assign s_axi_wready = (wr_state_r == RCAM_CH_IDLE) && !w_held_r;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   // address and data may arrive in either order; commit once both are held
   assign wr_fire = (wr_state_r == RCAM_CH_IDLE) && aw_held_r && w_held_r;

   assign wr_hit_global = (awaddr_r == RCAM_OFF_GLOBAL_CTRL);
   assign wr_hit_alias = (awaddr_r == RCAM_OFF_RX_ALIAS);
   assign wr_hit_mask = (awaddr_r == RCAM_OFF_RX_MASK);
   assign wr_hit_pad = (awaddr_r == RCAM_OFF_RX_PAD);
   assign wr_mapped = wr_hit_global | wr_hit_alias | wr_hit_mask | wr_hit_pad;
   assign gctl_we = wr_fire && wr_hit_global;
   assign alias_we = wr_fire && wr_hit_alias;
   assign mask_we = wr_fire && wr_hit_mask;
   assign pad_we = wr_fire && wr_hit_pad;

   // one store for both paths
   // global writes reach every control bit, alias writes only the receive ones
   assign gctl_keep = RCAM_RX_CTRL_MASK | RCAM_TX_CTRL_MASK;
   assign alias_keep = RCAM_RX_CTRL_MASK;
   assign gctl_nxt = gctl_we ? rcam_merge(gctl_r, wdata_r, wstrb_r, gctl_keep) :
                     alias_we ? rcam_merge(gctl_r, wdata_r, wstrb_r, alias_keep) : gctl_r;
   assign mask_nxt = mask_we ? rcam_merge(mask_r, wdata_r, wstrb_r, '1) : mask_r;
   assign pad_nxt = pad_we ? rcam_merge(pad_r, wdata_r, wstrb_r, RCAM_PAD_REG_MASK) : pad_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end else if (aw_take) begin
         aw_held_r <= 1'b1;
         awaddr_r <= {s_axi_awaddr[RCAM_ADDR_W-1:2], 2'b00};
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (w_take) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_state_r <= RCAM_CH_IDLE;
         bresp_r <= RCAM_RESP_OKAY;
      end else begin
         unique case (wr_state_r)
            RCAM_CH_IDLE: begin
               if (wr_fire) begin
                  wr_state_r <= RCAM_CH_RESP;
                  bresp_r <= wr_mapped ? RCAM_RESP_OKAY : RCAM_RESP_SLVERR;
               end
            end
            RCAM_CH_RESP: begin
               if (s_axi_bready) begin
                  wr_state_r <= RCAM_CH_IDLE;
               end
            end
         endcase
      end
   end

   assign s_axi_bvalid = (wr_state_r == RCAM_CH_RESP);
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gctl_r <= RCAM_GLOBAL_RESET;
         mask_r <= RCAM_MASK_RESET;
         pad_r <= RCAM_PAD_RESET;
      end else begin
         gctl_r <= gctl_nxt;
         mask_r <= mask_nxt;
         pad_r <= pad_nxt;
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   rcam_ch_state_t rd_state_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [RCAM_ADDR_W-1:0] rd_addr;
   logic rd_hit_global;
   logic rd_hit_alias;
   logic rd_hit_mask;
   logic rd_hit_pad;
   logic [31:0] rd_value;

   assign s_axi_arready = (rd_state_r == RCAM_CH_IDLE);
   assign rd_addr = {s_axi_araddr[RCAM_ADDR_W-1:2], 2'b00};
   assign rd_hit_global = (rd_addr == RCAM_OFF_GLOBAL_CTRL);
   assign rd_hit_alias = (rd_addr == RCAM_OFF_RX_ALIAS);
   assign rd_hit_mask = (rd_addr == RCAM_OFF_RX_MASK);
   assign rd_hit_pad = (rd_addr == RCAM_OFF_RX_PAD);

   assign rd_value = (rd_hit_global | rd_hit_alias) ? (gctl_r & (RCAM_RX_CTRL_MASK | RCAM_TX_CTRL_MASK)) :
                     rd_hit_mask ? mask_r :
                     rd_hit_pad ? (pad_r & RCAM_PAD_REG_MASK) : '0;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_state_r <= RCAM_CH_IDLE;
         rdata_r <= '0;
         rresp_r <= RCAM_RESP_OKAY;
      end else begin
         unique case (rd_state_r)
            RCAM_CH_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state_r <= RCAM_CH_RESP;
                  rdata_r <= rd_value;
                  rresp_r <= (rd_hit_global | rd_hit_alias | rd_hit_mask | rd_hit_pad) ?
                             RCAM_RESP_OKAY : RCAM_RESP_SLVERR;
               end
            end
            RCAM_CH_RESP: begin
               if (s_axi_rready) begin
                  rd_state_r <= RCAM_CH_IDLE;
               end
            end
         endcase
      end
   end

   assign s_axi_rvalid = (rd_state_r == RCAM_CH_RESP);
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ****************************************
   // control levels
   // ****************************************
   // frame sync generator run
   assign rx_frame_sync_gen_run_o = gctl_r[RCAM_BIT_RX_FSG];
   assign rx_state_machine_run_o = gctl_r[RCAM_BIT_RX_SM];
   assign rx_serializer_active_o = gctl_r[RCAM_BIT_RX_SER];
   assign rx_hf_divider_run_o = gctl_r[RCAM_BIT_RX_HF_DIV];
   assign rx_hf_divider_bypass_o = ~gctl_r[RCAM_BIT_RX_HF_DIV];
   assign rx_divider_run_o = gctl_r[RCAM_BIT_RX_DIV];
   assign tx_frame_sync_gen_run_o = gctl_r[RCAM_BIT_TX_FSG];
   assign tx_state_machine_run_o = gctl_r[RCAM_BIT_TX_SM];
   assign tx_serializer_active_o = gctl_r[RCAM_BIT_TX_SER];
   assign tx_hf_divider_run_o = gctl_r[RCAM_BIT_TX_HF_DIV];
   assign tx_divider_run_o = gctl_r[RCAM_BIT_TX_DIV];

   // ****************************************
   // receive format mask
   // ****************************************
   rcam_fmt_if #(.DATA_W(DATA_W)) fmt_bus ();

   assign fmt_bus.word = rx_word_i;
   assign fmt_bus.word_valid = rx_word_valid_i;
   // mask and pad settings feed unit
   assign fmt_bus.mask = mask_r[DATA_W-1:0];
   assign fmt_bus.pad_sel = pad_r[RCAM_PAD_SEL_LSB +: 2];
   assign fmt_bus.pad_bit = pad_r[RCAM_PAD_BIT_LSB +: 5];
   assign fmt_bus.enable = gctl_r[RCAM_BIT_RX_SER];

   rcam_fmt_unit #(.DATA_W(DATA_W)) u_fmt (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .fmt(fmt_bus.fmt)
   );

   assign rx_data_o = fmt_bus.data;
   assign rx_data_valid_o = fmt_bus.data_valid;

endmodule
`default_nettype wire

/* File: hw/rcam_pkg.sv */
// constants and types shared by the receive control alias and mask block
package rcam_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] RCAM_OFF_GLOBAL_CTRL = 8'h00;
   localparam logic [7:0] RCAM_OFF_RX_ALIAS = 8'h04;
   localparam logic [7:0] RCAM_OFF_RX_MASK = 8'h08;
   localparam logic [7:0] RCAM_OFF_RX_PAD = 8'h0c;
   localparam int RCAM_ADDR_W = 8;

   // ****************************************
   // global control field layout
   // ****************************************
   localparam int RCAM_BIT_RX_DIV = 0;
   localparam int RCAM_BIT_RX_HF_DIV = 1;
   localparam int RCAM_BIT_RX_SER = 2;
   localparam int RCAM_BIT_RX_SM = 3;
   localparam int RCAM_BIT_RX_FSG = 4;
   localparam int RCAM_BIT_TX_DIV = 8;
   localparam int RCAM_BIT_TX_HF_DIV = 9;
   localparam int RCAM_BIT_TX_SER = 10;
   localparam int RCAM_BIT_TX_SM = 11;
   localparam int RCAM_BIT_TX_FSG = 12;
   localparam logic [31:0] RCAM_RX_CTRL_MASK = 32'h0000_001f;
   localparam logic [31:0] RCAM_TX_CTRL_MASK = 32'h0000_1f00;
   localparam logic [31:0] RCAM_GLOBAL_RESET = 32'h0000_0000;

   // ****************************************
   // receive mask and pad fields
   // ****************************************
   localparam logic [31:0] RCAM_MASK_RESET = 32'h0000_0000;
   localparam int RCAM_PAD_SEL_LSB = 13;
   localparam int RCAM_PAD_BIT_LSB = 8;
   localparam logic [31:0] RCAM_PAD_REG_MASK = 32'h0000_7f00;
   localparam logic [31:0] RCAM_PAD_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      RCAM_PAD_ZERO = 2'b00,
      RCAM_PAD_ONE = 2'b01,
      RCAM_PAD_FROM_BIT = 2'b10,
      RCAM_PAD_RSVD = 2'b11
   } rcam_pad_sel_t;

   // ****************************************
   // bus answers and channel states
   // ****************************************
   localparam logic [1:0] RCAM_RESP_OKAY = 2'b00;
   localparam logic [1:0] RCAM_RESP_SLVERR = 2'b10;

   typedef enum logic [0:0] {
      RCAM_CH_IDLE = 1'b0,
      RCAM_CH_RESP = 1'b1
   } rcam_ch_state_t;

endpackage

/* File: hw/rcam_fmt_if.sv */
// interface between the register bank and the receive format mask unit
`timescale 1ns/100ps
`default_nettype none
interface rcam_fmt_if #(parameter int DATA_W = 32);
   logic [DATA_W-1:0] word;
   logic word_valid;
   logic [DATA_W-1:0] mask;
   logic [1:0] pad_sel;
   logic [4:0] pad_bit;
   logic enable;
   logic [DATA_W-1:0] data;
   logic data_valid;

   modport bank (output word, output word_valid, output mask, output pad_sel, output pad_bit,
      output enable, input data, input data_valid);
   modport fmt (input word, input word_valid, input mask, input pad_sel, input pad_bit,
      input enable, output data, output data_valid);
endinterface
`default_nettype wire

/* File: hw/rcam_fmt_unit.sv */
// receive format mask unit: keeps or pads each received bit
`timescale 1ns/100ps
`default_nettype none
module rcam_fmt_unit
   import rcam_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   rcam_fmt_if.fmt fmt
);

   logic pad_value;
   logic [DATA_W-1:0] data_nxt;
   logic [DATA_W-1:0] data_r;
   logic valid_r;

   // ****************************************
   // pad value selection
   // ****************************************
   // reserved pad code falls back to zero padding
   assign pad_value = (fmt.pad_sel == RCAM_PAD_ONE) ? 1'b1 :
                      (fmt.pad_sel == RCAM_PAD_FROM_BIT) ? fmt.word[fmt.pad_bit] : 1'b0;

   // ****************************************
   // per-bit mask
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_bit
         assign data_nxt[gi] = fmt.mask[gi] ? fmt.word[gi] : pad_value;
      end
   endgenerate

   // cleared serializers deliver nothing
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data_r <= '0;
         valid_r <= 1'b0;
      end else begin
         valid_r <= fmt.word_valid & fmt.enable;
         if (fmt.word_valid & fmt.enable) begin
            data_r <= data_nxt;
         end
      end
   end

   assign fmt.data = data_r;
   assign fmt.data_valid = valid_r;

endmodule
`default_nettype wire

/* File: bench/rcam_checker.sv */
// concurrent checks on the receive control alias and mask bank ports
`timescale 1ns/100ps
`default_nettype none
module rcam_checker
   import rcam_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [RCAM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic rx_frame_sync_gen_run_o,
   input wire logic rx_state_machine_run_o,
   input wire logic rx_serializer_active_o,
   input wire logic rx_hf_divider_run_o,
   input wire logic rx_hf_divider_bypass_o,
   input wire logic rx_divider_run_o,
   input wire logic tx_frame_sync_gen_run_o,
   input wire logic tx_state_machine_run_o,
   input wire logic tx_serializer_active_o,
   input wire logic tx_hf_divider_run_o,
   input wire logic tx_divider_run_o,
   input wire logic rx_word_valid_i,
   input wire logic rx_data_valid_o
);
   logic [31:0] ctrl_w;
   logic [RCAM_ADDR_W-1:0] rd_addr_r;
   logic ctl_rd;
   // global register and alias share the lowest two words
   assign ctl_rd = (rd_addr_r[RCAM_ADDR_W-1:3] == '0);
   assign ctrl_w = {19'h0, tx_frame_sync_gen_run_o, tx_state_machine_run_o, tx_serializer_active_o,
      tx_hf_divider_run_o, tx_divider_run_o, 3'h0, rx_frame_sync_gen_run_o, rx_state_machine_run_o,
      rx_serializer_active_o, rx_hf_divider_run_o, rx_divider_run_o};
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_addr_r <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_r <= s_axi_araddr;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   a_hf_bypass_inverse: assert property (rx_hf_divider_bypass_o == !rx_hf_divider_run_o)
      else $error("bypass not inverse of divider run");
   a_rx_ctrl_commit: assert property (!$stable(ctrl_w[4:0]) |-> s_axi_bvalid)
      else $error("receive control moved without a write");
   a_tx_ctrl_commit: assert property (!$stable(ctrl_w[12:8]) |-> s_axi_bvalid)
      else $error("transmit control moved without a write");
   a_ctrl_readback: assert property ($rose(s_axi_rvalid) && ctl_rd |-> s_axi_rdata == $past(ctrl_w))
      else $error("control read differs from control outputs");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_word_taken: assert property (rx_word_valid_i && rx_serializer_active_o |=> rx_data_valid_o)
      else $error("word not returned");
   a_word_dropped: assert property (rx_word_valid_i && !rx_serializer_active_o |=> !rx_data_valid_o)
      else $error("word returned while serializers cleared");
endmodule
bind rcam_top rcam_checker #(.DATA_W(DATA_W)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .rx_frame_sync_gen_run_o(rx_frame_sync_gen_run_o), .rx_state_machine_run_o(rx_state_machine_run_o),
   .rx_serializer_active_o(rx_serializer_active_o), .rx_hf_divider_run_o(rx_hf_divider_run_o),
   .rx_hf_divider_bypass_o(rx_hf_divider_bypass_o), .rx_divider_run_o(rx_divider_run_o),
   .tx_frame_sync_gen_run_o(tx_frame_sync_gen_run_o), .tx_state_machine_run_o(tx_state_machine_run_o),
   .tx_serializer_active_o(tx_serializer_active_o), .tx_hf_divider_run_o(tx_hf_divider_run_o),
   .tx_divider_run_o(tx_divider_run_o), .rx_word_valid_i(rx_word_valid_i), .rx_data_valid_o(rx_data_valid_o));
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the receive control alias and mask bank
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import rcam_pkg::*;
;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, word, rdata, dout;
   logic awvalid, wvalid, bready, arvalid, rready, word_v;
   logic awready, wready, bvalid, arready, rvalid, dvalid, byp;
   logic [1:0] bresp, rresp;
   wire [4:0] rxc, txc;
   int fails, total_checks;
   logic [31:0] glob, mask, pad;
   always #50 clk_i = ~clk_i;
   rcam_top #(.DATA_W(32)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rx_frame_sync_gen_run_o(rxc[4]), .rx_state_machine_run_o(rxc[3]), .rx_serializer_active_o(rxc[2]),
      .rx_hf_divider_run_o(rxc[1]), .rx_hf_divider_bypass_o(byp), .rx_divider_run_o(rxc[0]),
      .tx_frame_sync_gen_run_o(txc[4]), .tx_state_machine_run_o(txc[3]), .tx_serializer_active_o(txc[2]),
      .tx_hf_divider_run_o(txc[1]), .tx_divider_run_o(txc[0]), .rx_word_i(word), .rx_word_valid_i(word_v),
      .rx_data_o(dout), .rx_data_valid_o(dvalid));
   // ****************************************
   // bus tasks and model
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit pa, pw, ta, tw, b;
      logic [1:0] r;
      {pa, pw} = 2'b11;
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid} <= 2'b11;
      while (pa || pw) begin
         @(negedge clk_i);
         ta = pa && awready;
         tw = pw && wready;
         @(posedge clk_i);
         pa = pa && !ta;
         pw = pw && !tw;
         awvalid <= pa;
         wvalid <= pw;
      end
      // a late bready lets the held-answer check see a waiting response
      repeat ($urandom_range(2)) @(posedge clk_i);
      bready <= 1'b1;
      do begin
         @(negedge clk_i);
         b = bvalid;
         r = bresp;
         @(posedge clk_i);
      end while (!b);
      bready <= 1'b0;
      case (a[7:2])
         6'd0: glob = d & 32'h1f1f;
         6'd1: glob = (glob & 32'h1f00) | (d & 32'h1f);
         6'd2: mask = d;
         6'd3: pad = d & 32'h7f00;
         default: ;
      endcase
      chk({30'h0, r}, (a > 8'h0f) ? 32'h2 : 32'h0, "write response");
      chk({19'h0, txc, 3'h0, rxc}, glob, "control outputs");
      chk({31'h0, byp}, {31'h0, !glob[1]}, "divide-by-one bypass");
   endtask
   task automatic rd(input logic [7:0] a);
      bit t, v;
      logic [31:0] d;
      logic [1:0] r;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge clk_i);
         t = arready;
         @(posedge clk_i);
      end while (!t);
      arvalid <= 1'b0;
      repeat ($urandom_range(2)) @(posedge clk_i);
      rready <= 1'b1;
      do begin
         @(negedge clk_i);
         {v, d, r} = {rvalid, rdata, rresp};
         @(posedge clk_i);
      end while (!v);
      rready <= 1'b0;
      chk(d, (a < 8'h08) ? glob : (a < 8'h0c) ? mask : (a < 8'h10) ? pad : 32'h0, "read data");
      chk({30'h0, r}, (a > 8'h0f) ? 32'h2 : 32'h0, "read response");
   endtask
   // back-to-back received words, checked one cycle later against the model
   task automatic dp(input int n);
      logic [31:0] q[$];
      logic [31:0] w;
      bit ser, pv;
      ser = glob[2];
      for (int i = 0; i <= n; i++) begin
         w = $urandom;
         word <= w;
         word_v <= (i < n);
         @(negedge clk_i);
         if (i > 0) chk({31'h0, dvalid}, {31'h0, ser}, "word valid");
         if (i > 0 && ser) chk(dout, q.pop_front(), "masked word");
         pv = (pad[14:13] == 2'd1) || (pad[14:13] == 2'd2 && w[pad[12:8]]);
         q.push_back((w & mask) | (~mask & {32{pv}}));
         @(posedge clk_i);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      {awaddr, araddr, wdata, word} = '0;
      {awvalid, wvalid, bready, arvalid, rready, word_v} = '0;
      {fails, total_checks} = '0;
      {glob, mask, pad} = '0;
      void'($urandom(32'h3f4d));
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 0; a < 20; a += 4) rd(8'(a));
      $display("reset value test done");
      wr(8'h00, 32'hffff_ffff);
      wr(8'h04, 32'hffff_ffe0);
      rd(8'h04);
      wr(8'h04, 32'h0000_001f);
      rd(8'h00);
      $display("alias test done");
      repeat (40) begin
         wr({3'h0, 3'($urandom), 2'h0}, $urandom);
         rd({3'h0, 3'($urandom), 2'h0});
      end
      $display("random register test done");
      for (int s = 0; s < 5; s++) begin
         wr(8'h08, $urandom);
         wr(8'h0c, {17'h0, 2'(s), 5'($urandom), 8'h0});
         wr(8'h04, (s == 4) ? 32'h1b : 32'h1f);
         dp(8);
      end
      $display("mask and pad test done");
      conclude();
   end
   initial begin
      #(100 * 20000);
      fails++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
   end
endmodule
`default_nettype wire
